// ==== dctu_map.svh ====
// Register indices, field positions, reset values and fixed counts
// of the dual counter/timer unit.
// Assumes byte address = 4 * index on a 32-bit register bus.
`ifndef DCTU_MAP_SVH
`define DCTU_MAP_SVH
// Register indices (word address = index)
`define DCTU_IDX_NCTRL  4'h0
`define DCTU_IDX_MODE   4'h1
`define DCTU_IDX_WCTRL  4'h2
`define DCTU_IDX_NLOW   4'h4
`define DCTU_IDX_NHIGH  4'h5
`define DCTU_IDX_WLOW   4'h6
`define DCTU_IDX_WHIGH  4'h7
`define DCTU_IDX_CAPLO  4'h8
`define DCTU_IDX_CAPHI  4'h9
// Address bits that select the index
`define DCTU_IDX_MSB    5
`define DCTU_IDX_LSB    2
// Narrow timer control fields
`define DCTU_NC_EN      7
`define DCTU_NC_SINGLE  6
`define DCTU_NC_TOUT    5
`define DCTU_NC_CLK_HI  4
`define DCTU_NC_CLK_LO  3
`define DCTU_NC_CAPIE   2
`define DCTU_NC_TOIE    1
`define DCTU_NC_PINSEL  0
// Timer mode control fields
`define DCTU_MC_DEMOD   6
`define DCTU_MC_OM_HI   3
`define DCTU_MC_OM_LO   2
`define DCTU_MC_ST_HI   1
`define DCTU_MC_INIT    0
// Wide timer control fields
`define DCTU_WC_EN      7
`define DCTU_WC_SINGLE  6
`define DCTU_WC_STAT    5
`define DCTU_WC_IE      1
// Reset values and fixed counts
`define DCTU_RST_BYTE   8'h00
`define DCTU_RESTART    8'hFF
`define DCTU_CLK_DIV8   2'h3
`endif

// ==== dctu_pkg.sv ====
// Types shared by the dual counter/timer unit.
// Assumes dctu_map.svh is on the include path.
`default_nettype none
package dctu_pkg;
   // Bus phase, one-hot
   typedef enum logic [2:0] {
      PH_IDLE  = 3'b001,
      PH_WRITE = 3'b010,
      PH_READ  = 3'b100
   } dctu_phase_t;

   // Whole state of the top module
   typedef struct packed {
      logic [7:0]  nctrl;
      logic [7:0]  mode;
      logic [1:0]  edgeStat;
      logic [7:0]  wctrl;
      logic [7:0]  nlow;
      logic [7:0]  nhigh;
      logic [7:0]  wlow;
      logic [7:0]  whigh;
      logic [7:0]  capLo;
      logic [7:0]  capHi;
      logic [7:0]  ncnt;
      logic        nout;
      logic        demodPrev;
      logic        wStart;
      dctu_phase_t phase;
      logic [3:0]  addrIdx;
      logic        hit;
      logic [31:0] rdata;
      logic        ready;
      logic        resp;
      logic        nPin;
      logic        wPin;
      logic        nIrq;
      logic        capIrq;
      logic        wIrq;
   } dctu_state_t;
endpackage : dctu_pkg
`default_nettype wire

// ==== dctu_wide_if.sv ====
// Control and status link between the top and the wide counter.
// Assumes a single clock domain on both ends.
`timescale 1ns/1ps
`default_nettype none
interface dctu_wide_if #(parameter int W = 16);
   logic         enable;
   logic         start;
   logic         singlePass;
   logic         initLevel;
   logic [1:0]   outMode;
   logic [W-1:0] holdValue;
   logic [W-1:0] count;
   logic         outLevel;
   logic         zeroHit;
   modport ctl (output enable, start, singlePass, initLevel, outMode, holdValue,
                input count, outLevel, zeroHit);
   modport cnt (input enable, start, singlePass, initLevel, outMode, holdValue,
                output count, outLevel, zeroHit);
endinterface : dctu_wide_if
`default_nettype wire

// ==== dctu_prescale.sv ====
// Free-running system clock prescaler for the narrow counter.
// Assumes divSel is a register of the same clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "dctu_map.svh"
module dctu_prescale #(
   parameter int DIV_W = 3
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Divider select and tick
   input  wire logic [1:0] divSel,
   output logic            tick
);
   typedef struct packed {
      logic [DIV_W-1:0] div;
   } dctu_pre_state_t;

   dctu_pre_state_t s, ns;
   logic [DIV_W-1:0] mask;

   if (DIV_W < 3) begin : g_chk
      $error("dctu_prescale: DIV_W must be at least 3");
   end

   // Never aligned to enable, so the first tick may be short
   always_comb begin
      ns = s;
      ns.div = s.div + DIV_W'(1);
      mask = DIV_W'((1 << divSel) - 1);
      tick = ((s.div & mask) == mask);
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= ns;
      end
   end

   // Two divide-by-eight ticks never fall on adjacent edges
   div8_tick_a: assert property (@(posedge clock) disable iff (!rst_n)
      (divSel == `DCTU_CLK_DIV8 && $stable(divSel) && tick) |-> !$past(tick))
      else $error("divide-by-eight ticks too close");
endmodule : dctu_prescale
`default_nettype wire

// ==== dctu_wide_counter.sv ====
// Sixteen-bit down-counter with its transmit output.
// Assumes start is a one-cycle pulse and enable is cleared by the top.
`timescale 1ns/1ps
`default_nettype none
`include "dctu_map.svh"
module dctu_wide_counter #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // Link to the top
   dctu_wide_if.cnt  ifc
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         lvl;
   } dctu_wide_state_t;

   dctu_wide_state_t s, ns;
   logic zero;

   if (W < 2) begin : g_chk
      $error("dctu_wide_counter: W must be at least 2");
   end

   // Hold value is read on a load and on each reload at zero
   always_comb begin
      ns = s;
      zero = 1'b0;
      if (ifc.start) begin
         ns.cnt = ifc.holdValue;
         ns.lvl = ifc.initLevel;
      end else if (ifc.enable) begin
         if (s.cnt == '0) begin
            zero = 1'b1;
            ns.lvl = ~s.lvl;
            ns.cnt = ifc.singlePass ? s.cnt : ifc.holdValue;
         end else begin
            ns.cnt = s.cnt - W'(1);
         end
      end else begin
         ns.lvl = ~ifc.initLevel;
      end
   end

   // Forced modes override the counter level in every state
   assign ifc.outLevel = ifc.outMode[1] ? ifc.outMode[0] : s.lvl;
   assign ifc.count = s.cnt;
   assign ifc.zeroHit = zero;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= ns;
      end
   end

   wide_load_a: assert property (@(posedge clock) disable iff (!rst_n)
      ifc.start |=> (s.cnt == $past(ifc.holdValue)) && (s.lvl == $past(ifc.initLevel)))
      else $error("wide counter load wrong");
endmodule : dctu_wide_counter
`default_nettype wire

// ==== dctu_top.sv ====
// Dual counter/timer unit: AHB-Lite register slave, narrow counter
// with demodulation capture, and the wide counter instance.
// Assumes pin inputs synchronous to clock and single word transfers.
`timescale 1ns/1ps
`default_nettype none
`include "dctu_map.svh"
module dctu_top
   import dctu_pkg::*;
#(
   parameter int ADDR_W = 6,
   parameter int DIV_W  = 3,
   parameter int WIDE_W = 16
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [ADDR_W-1:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Pins
   input  wire logic        demodIn,
   input  wire logic        portData,
   output logic             narrowOutputPin,
   output logic             wideTimerOutput,
   // Interrupt requests, one-cycle pulses
   output logic             narrowTimeoutIrq,
   output logic             captureIrq,
   output logic             wideTimeoutIrq
);
   import dctu_pkg::*;

   dctu_state_t s, ns;
   dctu_wide_if #(.W(WIDE_W)) wideIf ();

   logic       tick;
   logic       addrTaken;
   logic       wr;
   logic [7:0] wd;
   logic [7:0] rdByte;
   logic [7:0] nLoad;
   logic       demod;
   logic       nEn;
   logic       edgeSeen;
   logic       toutSet;
   logic       capEv;
   logic       fallSet;
   logic       riseSet;

   if (ADDR_W < `DCTU_IDX_MSB + 1) begin : g_chk
      $error("dctu_top: ADDR_W too small for the register map");
   end
   if (WIDE_W != 16) begin : g_chk_w
      $error("dctu_top: hold registers serve a 16-bit wide counter only");
   end

   // Prescaled tick for the narrow counter
   dctu_prescale #(.DIV_W(DIV_W)) u_pre (
      .clock  (clock),
      .rst_n  (rst_n),
      .divSel (s.nctrl[`DCTU_NC_CLK_HI:`DCTU_NC_CLK_LO]),
      .tick   (tick)
   );

   // Wide counter and its controls
   dctu_wide_counter #(.W(WIDE_W)) u_wide (
      .clock (clock),
      .rst_n (rst_n),
      .ifc   (wideIf.cnt)
   );

   assign wideIf.enable     = s.wctrl[`DCTU_WC_EN];
   assign wideIf.start      = s.wStart;
   assign wideIf.singlePass = s.wctrl[`DCTU_WC_SINGLE];
   assign wideIf.initLevel  = s.mode[`DCTU_MC_INIT];
   assign wideIf.outMode    = s.mode[`DCTU_MC_OM_HI:`DCTU_MC_OM_LO];
   assign wideIf.holdValue  = {s.whigh, s.wlow};

   // Decoded bus and mode terms
   assign addrTaken = hsel && hready && htrans[1];
   assign wr        = (s.phase == PH_WRITE) && s.hit;
   assign wd        = hwdata[7:0];
   assign demod     = s.mode[`DCTU_MC_DEMOD];
   assign nEn       = s.nctrl[`DCTU_NC_EN];
   assign nLoad     = s.nout ? s.nhigh : s.nlow;

   // Read data mux; status bits of mode read as edge flags in demod
   always_comb begin
      rdByte = `DCTU_RST_BYTE;
      unique case (s.addrIdx)
         `DCTU_IDX_NCTRL: rdByte = s.nctrl;
         `DCTU_IDX_MODE:  rdByte = demod ? {s.mode[7:2], s.edgeStat} : s.mode;
         `DCTU_IDX_WCTRL: rdByte = s.wctrl;
         `DCTU_IDX_NLOW:  rdByte = s.nlow;
         `DCTU_IDX_NHIGH: rdByte = s.nhigh;
         `DCTU_IDX_WLOW:  rdByte = s.wlow;
         `DCTU_IDX_WHIGH: rdByte = s.whigh;
         `DCTU_IDX_CAPLO: rdByte = s.capLo;
         `DCTU_IDX_CAPHI: rdByte = s.capHi;
         default:         rdByte = `DCTU_RST_BYTE;
      endcase
      if (!s.hit) begin
         rdByte = `DCTU_RST_BYTE;
      end
   end

   // Next state: bus, narrow counter, writes, then sticky sets
   always_comb begin
      ns = s;
      toutSet = 1'b0;
      capEv = 1'b0;
      fallSet = 1'b0;
      riseSet = 1'b0;
      edgeSeen = demod && nEn && (demodIn != s.demodPrev);
      ns.wStart = 1'b0;
      ns.ready = 1'b1;
      ns.resp = 1'b0;
      ns.demodPrev = demodIn;

      // One wait state on reads so a read right after a write sees it
      unique case (s.phase)
         PH_IDLE:  ns.phase = PH_IDLE;
         PH_WRITE: ns.phase = PH_IDLE;
         PH_READ: begin
            ns.phase = PH_IDLE;
            ns.rdata = 32'(rdByte);
         end
      endcase
      if (addrTaken) begin
         ns.addrIdx = haddr[`DCTU_IDX_MSB:`DCTU_IDX_LSB];
         ns.hit = (haddr >> (`DCTU_IDX_MSB + 1)) == '0;
         ns.phase = hwrite ? PH_WRITE : PH_READ;
         ns.ready = hwrite;
      end

      // Narrow counter; a capture edge takes priority over a tick
      if (edgeSeen) begin
         if (s.demodPrev) begin
            ns.capHi = s.ncnt;
            fallSet = 1'b1;
         end else begin
            ns.capLo = s.ncnt;
            riseSet = 1'b1;
         end
         ns.ncnt = `DCTU_RESTART;
         capEv = 1'b1;
      end else if (nEn && tick) begin
         if (s.ncnt == `DCTU_RST_BYTE) begin
            toutSet = 1'b1;
            if (demod) begin
               ns.ncnt = `DCTU_RESTART;
            end else begin
               ns.nout = ~s.nout;
               if (s.nctrl[`DCTU_NC_SINGLE]) begin
                  ns.nctrl[`DCTU_NC_EN] = 1'b0;
               end else begin
                  ns.ncnt = s.nout ? s.nlow : s.nhigh;
               end
            end
         end else begin
            ns.ncnt = s.ncnt - 8'h01;
         end
      end

      // Wide single pass clears its own enable at zero
      if (wideIf.zeroHit && s.wctrl[`DCTU_WC_SINGLE]) begin
         ns.wctrl[`DCTU_WC_EN] = 1'b0;
      end

      // Register writes in the data phase; status bits write-one-clear
      if (wr) begin
         unique case (s.addrIdx)
            `DCTU_IDX_NCTRL: begin
               ns.nctrl = wd;
               ns.nctrl[`DCTU_NC_TOUT] = s.nctrl[`DCTU_NC_TOUT] & ~wd[`DCTU_NC_TOUT];
               if (wd[`DCTU_NC_EN] && !nEn) begin
                  ns.ncnt = demod ? `DCTU_RESTART : nLoad;
               end
            end
            `DCTU_IDX_MODE: begin
               ns.mode = wd;
               if (demod) begin
                  ns.mode[`DCTU_MC_ST_HI:0] = s.mode[`DCTU_MC_ST_HI:0];
                  ns.edgeStat = s.edgeStat & ~wd[`DCTU_MC_ST_HI:0];
               end
            end
            `DCTU_IDX_WCTRL: begin
               ns.wctrl = wd;
               ns.wctrl[`DCTU_WC_STAT] = s.wctrl[`DCTU_WC_STAT] & ~wd[`DCTU_WC_STAT];
               ns.wStart = wd[`DCTU_WC_EN] && !s.wctrl[`DCTU_WC_EN];
            end
            `DCTU_IDX_NLOW:  ns.nlow = wd;
            `DCTU_IDX_NHIGH: ns.nhigh = wd;
            `DCTU_IDX_WLOW:  ns.wlow = wd;
            `DCTU_IDX_WHIGH: ns.whigh = wd;
            default:         ns.hit = s.hit;
         endcase
      end

      // Hardware sets win over a same-cycle software clear
      ns.nctrl[`DCTU_NC_TOUT] = ns.nctrl[`DCTU_NC_TOUT] | toutSet;
      ns.edgeStat = ns.edgeStat | {fallSet, riseSet};
      ns.wctrl[`DCTU_WC_STAT] = ns.wctrl[`DCTU_WC_STAT] | wideIf.zeroHit;

      // Interrupt pulses gated by their enables
      ns.nIrq = toutSet && s.nctrl[`DCTU_NC_TOIE];
      ns.capIrq = capEv && s.nctrl[`DCTU_NC_CAPIE];
      ns.wIrq = wideIf.zeroHit && s.wctrl[`DCTU_WC_IE];

      // Pins registered so outputs come from flops
      ns.nPin = s.nctrl[`DCTU_NC_PINSEL] ? s.nout : portData;
      ns.wPin = wideIf.outLevel;
   end

   // All state in one register; enum reset to its idle code
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.phase <= PH_IDLE;
         s.ready <= 1'b1;
      end else begin
         s <= ns;
      end
   end

   // Outputs
   assign hreadyout        = s.ready;
   assign hresp            = s.resp;
   assign hrdata           = s.rdata;
   assign narrowOutputPin  = s.nPin;
   assign wideTimerOutput  = s.wPin;
   assign narrowTimeoutIrq = s.nIrq;
   assign captureIrq       = s.capIrq;
   assign wideTimeoutIrq   = s.wIrq;

   // Stopped counter holds its value unless software writes
   run_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
      (!nEn && s.phase != PH_WRITE) |=> $stable(s.ncnt))
      else $error("stopped narrow counter moved");

   // Single pass clears the enable at terminal count outside demodulation mode
   single_halt_a: assert property (@(posedge clock) disable iff (!rst_n)
      (nEn && s.nctrl[`DCTU_NC_SINGLE] && !demod && tick && !edgeSeen
       && s.ncnt == `DCTU_RST_BYTE && s.phase != PH_WRITE) |=> !nEn)
      else $error("single pass did not halt");

   // Terminal count sets the flag unless a capture edge comes in the same cycle
   tout_set_a: assert property (@(posedge clock) disable iff (!rst_n)
      (nEn && tick && !edgeSeen && s.ncnt == `DCTU_RST_BYTE)
      |=> s.nctrl[`DCTU_NC_TOUT])
      else $error("timeout flag not set");

   // Flag survives anything but a write to its register
   tout_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      (s.nctrl[`DCTU_NC_TOUT] && !(wr && s.addrIdx == `DCTU_IDX_NCTRL))
      |=> s.nctrl[`DCTU_NC_TOUT])
      else $error("timeout flag lost");

   // Capture interrupt only with its enable
   cap_irq_a: assert property (@(posedge clock) disable iff (!rst_n)
      captureIrq |-> $past(s.nctrl[`DCTU_NC_CAPIE]) && $past(edgeSeen))
      else $error("capture interrupt while disabled");

   // Timeout interrupt only with its enable and a terminal count
   to_irq_a: assert property (@(posedge clock) disable iff (!rst_n)
      narrowTimeoutIrq |-> $past(s.nctrl[`DCTU_NC_TOIE]) && s.nctrl[`DCTU_NC_TOUT])
      else $error("timeout interrupt while disabled");

   // Port data reaches the pin one cycle later
   pin_sel_a: assert property (@(posedge clock) disable iff (!rst_n)
      !s.nctrl[`DCTU_NC_PINSEL] |=> narrowOutputPin == $past(portData))
      else $error("port data not on pin");

   // Capture restarts the count from all ones
   demod_ff_a: assert property (@(posedge clock) disable iff (!rst_n)
      (edgeSeen && !(wr && s.addrIdx == `DCTU_IDX_NCTRL))
      |=> s.ncnt == `DCTU_RESTART)
      else $error("capture did not restart count");

   // Forced wide output follows the mode bit one cycle on
   wide_force_a: assert property (@(posedge clock) disable iff (!rst_n)
      (wideIf.outMode[1] && $stable(wideIf.outMode)) |=> wideTimerOutput == $past(wideIf.outMode[0]))
      else $error("forced wide output wrong");

   // Wide zero sets the status bit
   wide_stat_a: assert property (@(posedge clock) disable iff (!rst_n)
      wideIf.zeroHit |=> s.wctrl[`DCTU_WC_STAT])
      else $error("wide status not set");
endmodule : dctu_top
`default_nettype wire

// ==== dctu_top_tb_top.sv ====
// Self-checking testbench of the dual counter/timer unit.
// Assumes an AHB-Lite master of single word transfers, a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "dctu_map.svh"
module dctu_top_tb_top;
   import dctu_pkg::*;
   // Design ports
   logic        clock;
   logic        rst_n;
   logic        hsel;
   logic [5:0]  haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   wire  logic  hreadyout;
   wire  logic  hresp;
   wire  logic [31:0] hrdata;
   logic        demodIn;
   logic        portData;
   wire  logic  narrowOutputPin;
   wire  logic  wideTimerOutput;
   wire  logic  narrowTimeoutIrq;
   wire  logic  captureIrq;
   wire  logic  wideTimeoutIrq;
   // Bench state
   int          failures;
   int          testsRun;
   int          cycleNo;
   logic [31:0] busData;
   logic        busResp;

   dctu_top i_dctu_top (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .demodIn(demodIn), .portData(portData),
      .narrowOutputPin(narrowOutputPin), .wideTimerOutput(wideTimerOutput),
      .narrowTimeoutIrq(narrowTimeoutIrq), .captureIrq(captureIrq), .wideTimeoutIrq(wideTimeoutIrq));

   // Clock at 100 ns
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", testsRun, failures);
      if (failures == 0 && testsRun > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   // Watchdog; the whole run needs well under 20000 cycles
   always @(posedge clock) begin
      cycleNo <= cycleNo + 1;
      if (cycleNo > 20000) begin
         failures++;
         report_and_stop();
      end
   end

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_val

   task automatic check_near(input logic [7:0] got, input logic [7:0] exp, input int tol);
      testsRun++;
      if (^got === 1'bx || got > exp + tol || got + tol < exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_near

   // Hreadyout seen at the falling edge is what the next rising edge samples
   task automatic wait_ready;
      @(negedge clock);
      while (hreadyout !== 1'b1) @(negedge clock);
      busData = hrdata;
      busResp = hresp;
      @(posedge clock);
   endtask : wait_ready

   // One transfer, entered right after a rising edge
   task automatic bus_xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {idx, 2'h0};
      hwrite <= wr;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h000000, wd};
      wait_ready();
   endtask : bus_xfer

   task automatic reg_write(input logic [3:0] idx, input logic [7:0] wd);
      bus_xfer(1'b1, idx, wd);
   endtask : reg_write

   task automatic reg_read(input logic [3:0] idx);
      bus_xfer(1'b0, idx, 8'h00);
   endtask : reg_read

   // Wait for an interrupt pulse: 0 timeout, 1 capture, 2 wide
   task automatic wait_irq(input int which, input int limit, output logic seen, output int at);
      int n;
      n = 0;
      seen = 1'b0;
      while (!seen && n < limit) begin
         @(posedge clock);
         #1;
         n++;
         case (which)
            0: seen = (narrowTimeoutIrq === 1'b1);
            1: seen = (captureIrq === 1'b1);
            default: seen = (wideTimeoutIrq === 1'b1);
         endcase
      end
      at = cycleNo;
   endtask : wait_irq

   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask : end_test

   // Main sequence
   initial begin
      logic       seen;
      int         t0;
      int         t1;
      int         t2;
      int         ones;
      logic [7:0] cv;
      {rst_n, hsel, haddr, htrans, hwrite, hwdata, demodIn, portData} = '0;
      hsize = 3'h2;
      failures = 0;
      testsRun = 0;
      cycleNo = 0;
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      // Reset values and unmapped places
      reg_read(`DCTU_IDX_NCTRL); check_val(busData, 32'h00000000);
      check_val(busResp, 1'b0);
      reg_write(4'h3, 8'h55); reg_read(4'h3); check_val(busData, 32'h00000000);
      reg_write(`DCTU_IDX_NLOW, 8'h05); reg_write(`DCTU_IDX_NHIGH, 8'h05);
      reg_read(`DCTU_IDX_NHIGH); check_val(busData, 32'h00000005);
      end_test("reset");
      // Period for every clock divider, modulo reload
      for (int d = 0; d < 4; d++) begin
         cv = 8'hA2 | (8'(d) << 3);
         reg_write(`DCTU_IDX_NCTRL, cv);
         wait_irq(0, 100, seen, t1);
         wait_irq(0, 100, seen, t2);
         check_val(t2 - t1, 6 << d);
         reg_write(`DCTU_IDX_NCTRL, 8'h00);
      end
      reg_read(`DCTU_IDX_NCTRL); check_val(busData, 32'h00000020);
      reg_write(`DCTU_IDX_NCTRL, 8'h00); reg_read(`DCTU_IDX_NCTRL); check_val(busData, 32'h00000020);
      reg_write(`DCTU_IDX_NCTRL, 8'h20); reg_read(`DCTU_IDX_NCTRL); check_val(busData, 32'h00000000);
      end_test("narrow period");
      // Gated timeout interrupt, then single pass
      reg_write(`DCTU_IDX_NCTRL, 8'h80);
      wait_irq(0, 20, seen, t1); check_val(seen, 1'b0);
      reg_write(`DCTU_IDX_NCTRL, 8'h00); reg_read(`DCTU_IDX_NCTRL); check_val(busData, 32'h00000020);
      reg_write(`DCTU_IDX_NCTRL, 8'hE2);
      wait_irq(0, 20, seen, t1); check_val(seen, 1'b1);
      wait_irq(0, 30, seen, t1); check_val(seen, 1'b0);
      reg_read(`DCTU_IDX_NCTRL); check_val(busData, 32'h00000062);
      reg_write(`DCTU_IDX_NCTRL, 8'h20);
      end_test("narrow single");
      // Output pin source
      portData <= 1'b1; repeat (3) @(posedge clock); #1;
      check_val(narrowOutputPin, 1'b1);
      portData <= 1'b0; repeat (3) @(posedge clock); #1;
      check_val(narrowOutputPin, 1'b0);
      @(posedge clock);
      reg_write(`DCTU_IDX_NCTRL, 8'h81);
      ones = 0;
      repeat (24) begin
         @(posedge clock); #1;
         if (narrowOutputPin === 1'b1) ones++;
      end
      check_val(ones, 12);
      @(posedge clock);
      reg_write(`DCTU_IDX_NCTRL, 8'h20);
      end_test("pin select");
      // Demodulation captures on both edges
      reg_write(`DCTU_IDX_MODE, 8'h40);
      reg_write(`DCTU_IDX_NCTRL, 8'h84);
      t0 = cycleNo;
      repeat (10) @(posedge clock);
      demodIn <= 1'b1; t1 = cycleNo;
      wait_irq(1, 5, seen, t2); check_val(seen, 1'b1);
      repeat (17) @(posedge clock);
      demodIn <= 1'b0; t2 = cycleNo;
      wait_irq(1, 5, seen, ones); check_val(seen, 1'b1);
      @(posedge clock);
      reg_read(`DCTU_IDX_CAPLO); check_near(busData[7:0], 8'hFF - 8'(t1 - t0), 3);
      reg_read(`DCTU_IDX_CAPHI); check_near(busData[7:0], 8'hFF - 8'(t2 - t1), 3);
      reg_read(`DCTU_IDX_MODE); check_val(busData, 32'h00000043);
      repeat (300) @(posedge clock);
      reg_read(`DCTU_IDX_NCTRL); check_val(busData, 32'h000000A4);
      reg_write(`DCTU_IDX_NCTRL, 8'hA0);
      demodIn <= 1'b1;
      wait_irq(1, 10, seen, t1); check_val(seen, 1'b0);
      @(posedge clock);
      reg_write(`DCTU_IDX_NCTRL, 8'h20);
      reg_write(`DCTU_IDX_MODE, 8'h03);
      reg_write(`DCTU_IDX_MODE, 8'h00);
      end_test("demodulation");
      // Wide output levels while disabled and forced
      repeat (3) @(posedge clock); #1; check_val(wideTimerOutput, 1'b1);
      @(posedge clock);
      reg_write(`DCTU_IDX_MODE, 8'h01); repeat (3) @(posedge clock); #1;
      check_val(wideTimerOutput, 1'b0);
      @(posedge clock);
      reg_write(`DCTU_IDX_MODE, 8'h0C); repeat (3) @(posedge clock); #1;
      check_val(wideTimerOutput, 1'b1);
      @(posedge clock);
      reg_write(`DCTU_IDX_MODE, 8'h08); repeat (3) @(posedge clock); #1;
      check_val(wideTimerOutput, 1'b0);
      @(posedge clock);
      reg_write(`DCTU_IDX_MODE, 8'h01);
      end_test("wide levels");
      // Wide modulo count, hold update at next load
      reg_write(`DCTU_IDX_WLOW, 8'h02); reg_write(`DCTU_IDX_WHIGH, 8'h01);
      reg_write(`DCTU_IDX_WCTRL, 8'h82);
      repeat (4) @(posedge clock); #1; check_val(wideTimerOutput, 1'b1);
      wait_irq(2, 300, seen, t1);
      repeat (3) @(posedge clock); #1; check_val(wideTimerOutput, 1'b0);
      @(posedge clock);
      reg_write(`DCTU_IDX_WLOW, 8'h05);
      wait_irq(2, 300, seen, t2); check_val(t2 - t1, 259);
      wait_irq(2, 300, seen, t1); check_val(t1 - t2, 262);
      reg_read(`DCTU_IDX_WCTRL); check_val(busData, 32'h000000A2);
      reg_write(`DCTU_IDX_WCTRL, 8'h20);
      reg_write(`DCTU_IDX_WCTRL, 8'hC2);
      wait_irq(2, 300, seen, t1); check_val(seen, 1'b1);
      wait_irq(2, 300, seen, t1); check_val(seen, 1'b0);
      reg_read(`DCTU_IDX_WCTRL); check_val(busData, 32'h00000062);
      end_test("wide counter");
      report_and_stop();
   end
endmodule : dctu_top_tb_top
`default_nettype wire
